// ---- hw/nvm_cmd_prot_map.vh ----
// Register map, field positions, command codes and reset values of the
// memory controller command and protection block.
// Assumes an 8-bit register port with byte offsets as listed here.
`ifndef NVM_CMD_PROT_MAP_VH
`define NVM_CMD_PROT_MAP_VH

`define OFS_COMMAND_SELECT   4'h0
`define OFS_PROT_AND_MAP     4'h1
`define OFS_CTRL_STATUS      4'h2
`define OFS_IRQ_ENABLE       4'h3
`define OFS_IRQ_FLAGS        4'h4
`define OFS_READ_DATA_LO     4'h6
`define OFS_READ_DATA_HI     4'h7
`define OFS_LAST_ADDR_0      4'h8
`define OFS_LAST_ADDR_1      4'h9
`define OFS_LAST_ADDR_2      4'ha

`define RST_COMMAND_SELECT   7'h00
`define RST_PROT_AND_MAP     8'h30
`define RST_ERROR            3'h0

`define BIT_MAPPING_LOCK     7
`define BIT_MAP_HI           5
`define BIT_MAP_LO           4
`define BIT_APP_DATA_WP      2
`define BIT_BOOT_RP          1
`define BIT_APP_CODE_WP      0
`define BIT_ERROR_HI         6
`define BIT_ERROR_LO         4
`define BIT_EEPROM_BUSY      1
`define BIT_FLASH_BUSY       0
`define BIT_EEPROM_IDLE_IRQ  0

`define CMD_NO_COMMAND       7'h00
`define CMD_NO_OPERATION     7'h01
`define CMD_FLASH_WRITE      7'h02
`define CMD_FLASH_PAGE_ERASE 7'h08
`define CMD_FLASH_MPE_FIRST  7'h09
`define CMD_FLASH_MPE_LAST   7'h0d
`define CMD_EEPROM_WRITE     7'h12
`define CMD_EEPROM_ERASE_WR  7'h13
`define CMD_EEPROM_BYTE_ER   7'h18
`define CMD_EEPROM_MBE_FIRST 7'h19
`define CMD_EEPROM_MBE_LAST  7'h1d
`define CMD_WHOLE_CHIP_ERASE 7'h20
`define CMD_EEPROM_FULL_ER   7'h30

`define ERR_NONE             3'h0
`define ERR_UNSUPPORTED      3'h1
`define ERR_PROTECTED        3'h2
`define ERR_COLLISION        3'h3

`define SEC_BOOT             2'h0
`define SEC_APP_CODE         2'h1
`define SEC_APP_DATA         2'h2
`define SEC_EEPROM           2'h3

`endif

// ---- hw/pin_sync3.v ----
// Three-stage input synchroniser for levels arriving from outside the
// core clock domain. Assumes i_core_clk and active-low async reset.
`timescale 1ns/1ps
module pin_sync3 #(
  parameter WIDTH = 1
) (
  input  wire             i_core_clk,
  input  wire             i_arst_n,
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] stage2_ff;
  reg [WIDTH-1:0] stage3_ff;
  reg [WIDTH-1:0] level_ff;
  integer         b;
  reg [WIDTH-1:0] nxt_level;

  // A bit changes only once stages two and three agree, filtering glitches.
  always @* begin
    nxt_level = level_ff;
    for (b = 0; b < WIDTH; b = b + 1) begin
      if (stage2_ff[b] == stage3_ff[b]) begin
        nxt_level[b] = stage3_ff[b];
      end
    end
  end

  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_ff   <= {WIDTH{1'b0}};
      stage2_ff <= {WIDTH{1'b0}};
      stage3_ff <= {WIDTH{1'b0}};
      level_ff  <= {WIDTH{1'b0}};
    end else begin
      meta_ff   <= i_async;
      stage2_ff <= meta_ff;
      stage3_ff <= stage2_ff;
      level_ff  <= nxt_level;
    end
  end

  assign o_sync = level_ff;
endmodule // pin_sync3

// ---- hw/nvm_command_protection_ctrl.v ----
// Command, protection and mapping control of the memory controller.
// Assumes register port, store port and protection-key windows on
// i_core_clk; array busy flags and the preserve fuse arrive as pins.
`timescale 1ns/1ps
`include "nvm_cmd_prot_map.vh"

// Notes on behaviour
// - Ready flag sets whenever the EEPROM can take a new operation.
// - Interrupt is high while enable and ready flag are both set.
// - With no EEPROM operation running, controller sleeps with system.
// - A running EEPROM operation keeps memory and clock on until done.
// - The ready interrupt wakes the device from idle sleep only.
// - Protected writes without the right unlock leave the register.
// - Command register needs the self-program key, protection the I/O key.
// - Command codes 0x20 and 0x30 start their erase at once.
// - Other valid codes only arm; a store starts the operation.
// - Flash codes: 0x02 write, 0x08 page erase, 0x09-0x0d multi-page.
// - EEPROM codes 0x12, 0x13, 0x18, 0x19-0x1d; others reserved.
// - Chip erase skips EEPROM with preserve fuse; debug port only.
// - Mapping lock freezes the mapping field; cleared by reset only.
// - Mapping field picks a 32 KB section; smallest part always section 0.
// - Mapping field is writable without the unlock sequence.
// - Data write-protect blocks data section updates; reset clears it.
// - Boot read-protect: outside reads give zero, fetches give no-op.
// - Boot read-protect written from boot only; effective after leaving.
// - Error field codes 1, 2, 3; cleared by writing zero.
// - Ready flag stays set while EEPROM idles; write one clears it.
// - Code write-protect blocks code section updates; reset clears it.
module nvm_command_protection_ctrl #(
  parameter FLASH_KB = 32
) (
  input  wire        i_core_clk,
  input  wire        i_arst_n,
  input  wire [3:0]  i_reg_addr,
  input  wire [7:0]  i_reg_wdata,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  output wire [7:0]  o_reg_rdata,
  input  wire        i_self_program_key,
  input  wire        i_io_register_key,
  input  wire        i_from_debug_port,
  input  wire        i_exec_in_boot,
  input  wire        i_store_valid,
  input  wire [1:0]  i_store_section,
  input  wire [23:0] i_store_addr,
  input  wire [15:0] i_store_data,
  input  wire        i_array_rvalid,
  input  wire [15:0] i_array_rdata,
  input  wire        i_flash_busy_pin,
  input  wire        i_eeprom_busy_pin,
  input  wire        i_eeprom_preserve_fuse,
  input  wire        i_sleep_enter,
  input  wire        i_sleep_idle_mode,
  output wire        o_op_start,
  output wire [6:0]  o_op_cmd,
  output wire [23:0] o_op_addr,
  output wire [15:0] o_op_data,
  output wire        o_chip_erase_skip_eeprom,
  output wire [1:0]  o_data_space_section,
  output wire        o_boot_read_zero,
  output wire        o_boot_fetch_no_operation_cmd,
  output wire        o_eeprom_idle_irq,
  output wire        o_wake_request,
  output wire        o_ctrl_sleeping,
  output wire        o_keep_clock_on
);
  reg [7:0]  rdata_ff;
  reg [6:0]  command_ff;
  reg        mapping_lock_ff;
  reg [1:0]  flash_section_map_ff;
  reg        app_data_wp_ff;
  reg        boot_rp_ff;
  reg        app_code_wp_ff;
  reg [2:0]  error_ff;
  reg        irq_enable_ff;
  reg        irq_flag_ff;
  reg [15:0] data_ff;
  reg [23:0] addr_ff;
  reg        op_start_ff;
  reg [6:0]  op_cmd_ff;
  reg [23:0] op_addr_ff;
  reg [15:0] op_data_ff;
  reg        skip_ee_ff;
  reg [1:0]  section_ff;
  reg        boot_rp_active_ff;
  reg        irq_ff;
  reg        wake_ff;
  reg        sleeping_ff;
  reg        keep_clk_ff;
  reg        sleep_pending_ff;

  wire [2:0] pin_sync;
  wire       flash_busy;
  wire       eeprom_busy;
  wire       preserve_fuse;

  pin_sync3 #(
    .WIDTH (3)
  ) u_pin_sync (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_async    ({i_eeprom_preserve_fuse, i_eeprom_busy_pin,
                  i_flash_busy_pin}),
    .o_sync     (pin_sync)
  );

  assign flash_busy    = pin_sync[0];
  assign eeprom_busy   = pin_sync[1];
  assign preserve_fuse = pin_sync[2];

  // Command decode.
  wire [6:0] wcmd = i_reg_wdata[6:0];

  function cmd_valid;
    input [6:0] c;
    begin
      cmd_valid = (c == `CMD_NO_COMMAND) ||
                  (c == `CMD_NO_OPERATION) ||
                  (c == `CMD_FLASH_WRITE) ||
                  (c == `CMD_FLASH_PAGE_ERASE) ||
                  ((c >= `CMD_FLASH_MPE_FIRST) &&
                   (c <= `CMD_FLASH_MPE_LAST)) ||
                  (c == `CMD_EEPROM_WRITE) ||
                  (c == `CMD_EEPROM_ERASE_WR) ||
                  (c == `CMD_EEPROM_BYTE_ER) ||
                  ((c >= `CMD_EEPROM_MBE_FIRST) &&
                   (c <= `CMD_EEPROM_MBE_LAST)) ||
                  (c == `CMD_WHOLE_CHIP_ERASE) ||
                  (c == `CMD_EEPROM_FULL_ER);
    end
  endfunction

  function cmd_idle;
    input [6:0] c;
    begin
      cmd_idle = (c == `CMD_NO_COMMAND) || (c == `CMD_NO_OPERATION);
    end
  endfunction

  // Flash arming codes select the flash array; the rest target EEPROM.
  function cmd_is_flash;
    input [6:0] c;
    begin
      cmd_is_flash = (c == `CMD_FLASH_WRITE) ||
                     (c == `CMD_FLASH_PAGE_ERASE) ||
                     ((c >= `CMD_FLASH_MPE_FIRST) &&
                      (c <= `CMD_FLASH_MPE_LAST));
    end
  endfunction

  function cmd_is_eeprom;
    input [6:0] c;
    begin
      cmd_is_eeprom = (c == `CMD_EEPROM_WRITE) ||
                      (c == `CMD_EEPROM_ERASE_WR) ||
                      (c == `CMD_EEPROM_BYTE_ER) ||
                      ((c >= `CMD_EEPROM_MBE_FIRST) &&
                       (c <= `CMD_EEPROM_MBE_LAST));
    end
  endfunction

  wire wr_cmd  = i_reg_wr && (i_reg_addr == `OFS_COMMAND_SELECT);
  wire wr_prot = i_reg_wr && (i_reg_addr == `OFS_PROT_AND_MAP);
  wire wr_stat = i_reg_wr && (i_reg_addr == `OFS_CTRL_STATUS);
  wire wr_ien  = i_reg_wr && (i_reg_addr == `OFS_IRQ_ENABLE);
  wire wr_iflg = i_reg_wr && (i_reg_addr == `OFS_IRQ_FLAGS);

  // Each protected register opens only to its own key.
  wire cmd_unlocked  = wr_cmd && i_self_program_key;
  wire prot_unlocked = wr_prot && i_io_register_key;

  wire is_chip_erase = (wcmd == `CMD_WHOLE_CHIP_ERASE);
  // Chip erase from the CPU is refused as unsupported.
  wire chip_ok       = !is_chip_erase || i_from_debug_port;
  wire new_valid     = cmd_valid(wcmd) && chip_ok;
  wire collide       = cmd_unlocked && new_valid &&
                       !cmd_idle(command_ff) && !cmd_idle(wcmd) &&
                       (wcmd != command_ff);
  wire immediate     = cmd_unlocked && new_valid && !collide &&
                       (is_chip_erase ||
                        (wcmd == `CMD_EEPROM_FULL_ER));

  // A store runs the armed command if its section matches the armed array and is not write-locked.
  wire armed_flash  = cmd_is_flash(command_ff);
  wire armed_eeprom = cmd_is_eeprom(command_ff);
  wire sec_ok       = armed_eeprom ? (i_store_section == `SEC_EEPROM) :
                      (i_store_section != `SEC_EEPROM);
  wire sec_locked   = ((i_store_section == `SEC_APP_DATA) &&
                       app_data_wp_ff) ||
                      ((i_store_section == `SEC_APP_CODE) &&
                       app_code_wp_ff);
  wire store_go     = i_store_valid && (armed_flash || armed_eeprom) &&
                      sec_ok && !sec_locked;
  wire store_denied = i_store_valid && (armed_flash || armed_eeprom) &&
                      sec_ok && sec_locked;

  // Error field: a new error outranks a software clear in the same cycle.
  reg [2:0] nxt_error;
  always @* begin
    nxt_error = error_ff;
    if (wr_stat && (i_reg_wdata[`BIT_ERROR_HI:`BIT_ERROR_LO] == 3'h0)) begin
      nxt_error = `ERR_NONE;
    end
    if (cmd_unlocked && !new_valid) begin
      nxt_error = `ERR_UNSUPPORTED;
    end else if (collide) begin
      nxt_error = `ERR_COLLISION;
    end else if (store_denied) begin
      nxt_error = `ERR_PROTECTED;
    end
  end

  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      command_ff <= `RST_COMMAND_SELECT;
      error_ff   <= `RST_ERROR;
    end else begin
      error_ff <= nxt_error;
      // Reserved codes are rejected so nothing is armed by them.
      if (cmd_unlocked && new_valid && !collide) begin
        command_ff <= wcmd;
      end
    end
  end

  // Protection and mapping register.
  localparam [7:0] PROT_RESET = `RST_PROT_AND_MAP;
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mapping_lock_ff      <= PROT_RESET[`BIT_MAPPING_LOCK];
      flash_section_map_ff <= PROT_RESET[`BIT_MAP_HI:`BIT_MAP_LO];
      app_data_wp_ff       <= 1'b0;
      boot_rp_ff           <= 1'b0;
      app_code_wp_ff       <= 1'b0;
    end else begin
      // The map field ignores the key but honours the lock.
      if (wr_prot && !mapping_lock_ff) begin
        flash_section_map_ff <=
          i_reg_wdata[`BIT_MAP_HI:`BIT_MAP_LO];
      end
      // Lock and protection bits only set; nothing but reset clears them.
      if (prot_unlocked) begin
        mapping_lock_ff <= mapping_lock_ff |
                           i_reg_wdata[`BIT_MAPPING_LOCK];
        app_data_wp_ff  <= app_data_wp_ff |
                           i_reg_wdata[`BIT_APP_DATA_WP];
        app_code_wp_ff  <= app_code_wp_ff |
                           i_reg_wdata[`BIT_APP_CODE_WP];
        if (i_exec_in_boot) begin
          boot_rp_ff <= boot_rp_ff | i_reg_wdata[`BIT_BOOT_RP];
        end
      end
    end
  end

  // Interrupt control and the ready flag.
  // While the EEPROM idles the flag re-sets every cycle, so a clear
  // only sticks once an operation makes it busy.
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_enable_ff <= 1'b0;
      irq_flag_ff   <= 1'b0;
    end else begin
      if (wr_ien) begin
        irq_enable_ff <= i_reg_wdata[`BIT_EEPROM_IDLE_IRQ];
      end
      if (!eeprom_busy) begin
        irq_flag_ff <= 1'b1;
      end else if (wr_iflg && i_reg_wdata[`BIT_EEPROM_IDLE_IRQ]) begin
        irq_flag_ff <= 1'b0;
      end
    end
  end

  // Data and address: software may write them; hardware records the last
  // access, and hardware updates take priority.
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      data_ff <= 16'h0000;
      addr_ff <= 24'h000000;
    end else begin
      if (i_array_rvalid) begin
        data_ff <= i_array_rdata;
      end else if (i_reg_wr && (i_reg_addr == `OFS_READ_DATA_LO)) begin
        data_ff[7:0] <= i_reg_wdata;
      end else if (i_reg_wr && (i_reg_addr == `OFS_READ_DATA_HI)) begin
        data_ff[15:8] <= i_reg_wdata;
      end
      if (i_store_valid) begin
        addr_ff <= i_store_addr;
      end else if (i_reg_wr && (i_reg_addr == `OFS_LAST_ADDR_0)) begin
        addr_ff[7:0] <= i_reg_wdata;
      end else if (i_reg_wr && (i_reg_addr == `OFS_LAST_ADDR_1)) begin
        addr_ff[15:8] <= i_reg_wdata;
      end else if (i_reg_wr && (i_reg_addr == `OFS_LAST_ADDR_2)) begin
        addr_ff[23:16] <= i_reg_wdata;
      end
    end
  end

  // Array command issue.
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      op_start_ff <= 1'b0;
      op_cmd_ff   <= `CMD_NO_COMMAND;
      op_addr_ff  <= 24'h000000;
      op_data_ff  <= 16'h0000;
      skip_ee_ff  <= 1'b0;
    end else begin
      op_start_ff <= immediate || store_go;
      if (immediate) begin
        op_cmd_ff  <= wcmd;
        skip_ee_ff <= is_chip_erase && preserve_fuse;
      end else if (store_go) begin
        op_cmd_ff  <= command_ff;
        op_addr_ff <= i_store_addr;
        op_data_ff <= i_store_data;
        skip_ee_ff <= 1'b0;
      end
    end
  end

  // Mapping output; a part with one section maps it whatever the field.
  wire [1:0] map_sel = (FLASH_KB <= 32) ? 2'h0 :
                       (FLASH_KB <= 64) ? {1'b0, flash_section_map_ff[0]} :
                       flash_section_map_ff;

  // Boot read protection only bites once code has left the boot section,
  // so the boot loader can finish after setting the bit.
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      section_ff        <= 2'h0;
      boot_rp_active_ff <= 1'b0;
    end else begin
      section_ff <= map_sel;
      if (!boot_rp_ff) begin
        boot_rp_active_ff <= 1'b0;
      end else if (!i_exec_in_boot) begin
        boot_rp_active_ff <= 1'b1;
      end
    end
  end

  // Interrupt, wake and sleep handshake.
  wire ee_op_running = eeprom_busy;
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_ff           <= 1'b0;
      wake_ff          <= 1'b0;
      sleeping_ff      <= 1'b0;
      keep_clk_ff      <= 1'b0;
      sleep_pending_ff <= 1'b0;
    end else begin
      irq_ff  <= irq_enable_ff && irq_flag_ff;
      wake_ff <= irq_enable_ff && irq_flag_ff &&
                 i_sleep_enter && i_sleep_idle_mode;
      if (!i_sleep_enter) begin
        sleep_pending_ff <= 1'b0;
        sleeping_ff      <= 1'b0;
        keep_clk_ff      <= 1'b0;
      end else if (ee_op_running) begin
        // Memory and clocks stay up until the EEPROM operation ends.
        sleep_pending_ff <= 1'b1;
        sleeping_ff      <= 1'b0;
        keep_clk_ff      <= 1'b1;
      end else begin
        sleep_pending_ff <= 1'b0;
        sleeping_ff      <= 1'b1;
        keep_clk_ff      <= 1'b0;
      end
    end
  end

  // Register read mux; unmapped offsets read zero.
  reg [7:0] nxt_rdata;
  always @* begin
    case (i_reg_addr)
      `OFS_COMMAND_SELECT: nxt_rdata = {1'b0, command_ff};
      `OFS_PROT_AND_MAP:   nxt_rdata = {mapping_lock_ff, 1'b0,
                                        flash_section_map_ff, 1'b0,
                                        app_data_wp_ff, boot_rp_ff,
                                        app_code_wp_ff};
      `OFS_CTRL_STATUS:    nxt_rdata = {1'b0, error_ff, 2'b00,
                                        eeprom_busy, flash_busy};
      `OFS_IRQ_ENABLE:     nxt_rdata = {7'h00, irq_enable_ff};
      `OFS_IRQ_FLAGS:      nxt_rdata = {7'h00, irq_flag_ff};
      `OFS_READ_DATA_LO:   nxt_rdata = data_ff[7:0];
      `OFS_READ_DATA_HI:   nxt_rdata = data_ff[15:8];
      `OFS_LAST_ADDR_0:    nxt_rdata = addr_ff[7:0];
      `OFS_LAST_ADDR_1:    nxt_rdata = addr_ff[15:8];
      `OFS_LAST_ADDR_2:    nxt_rdata = addr_ff[23:16];
      default:             nxt_rdata = 8'h00;
    endcase
  end

  // Read data holds only in the cycle after the strobe, zero otherwise.
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= i_reg_rd ? nxt_rdata : 8'h00;
    end
  end

  assign o_reg_rdata              = rdata_ff;
  assign o_op_start               = op_start_ff;
  assign o_op_cmd                 = op_cmd_ff;
  assign o_op_addr                = op_addr_ff;
  assign o_op_data                = op_data_ff;
  assign o_chip_erase_skip_eeprom = skip_ee_ff;
  assign o_data_space_section     = section_ff;
  assign o_boot_read_zero         = boot_rp_active_ff;
  assign o_boot_fetch_no_operation_cmd        = boot_rp_active_ff;
  assign o_eeprom_idle_irq        = irq_ff;
  assign o_wake_request           = wake_ff;
  assign o_ctrl_sleeping          = sleeping_ff;
  assign o_keep_clock_on          = keep_clk_ff;
endmodule // nvm_command_protection_ctrl

// ---- verif/nvm_array_model.sv ----
// Stand-in for the Flash and EEPROM array behind the controller.
// Assumes the controller's start pulse and command on i_core_clk.
`timescale 1ns/1ps
module nvm_array_model #(
  parameter BUSY_CYC = 20
) (
  input  wire       i_core_clk,
  input  wire       i_arst_n,
  input  wire       i_op_start,
  input  wire [6:0] i_op_cmd,
  output reg        o_flash_busy,
  output reg        o_eeprom_busy
);
  integer cnt;
  // Busy levels are held long enough to outlast the controller's sync.
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt           <= 0;
      o_flash_busy  <= 1'b0;
      o_eeprom_busy <= 1'b0;
    end else if (i_op_start) begin
      cnt           <= BUSY_CYC;
      o_flash_busy  <= (i_op_cmd < 7'h12) || (i_op_cmd == 7'h20);
      o_eeprom_busy <= (i_op_cmd >= 7'h12);
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      cnt           <= 0;
      o_flash_busy  <= 1'b0;
      o_eeprom_busy <= 1'b0;
    end
  end
endmodule // nvm_array_model

// ---- verif/nvm_cmd_prot_assertions.sv ----
// Port-level checks of the command and protection controller.
// Bound into every instance; one clock domain, async low reset.
`timescale 1ns/1ps
module nvm_cmd_prot_checker #(
  parameter FLASH_KB = 32
) (
  input logic       i_core_clk,
  input logic       i_arst_n,
  input logic [3:0] i_reg_addr,
  input logic [7:0] i_reg_wdata,
  input logic       i_reg_wr,
  input logic       i_self_program_key,
  input logic       i_from_debug_port,
  input logic       i_exec_in_boot,
  input logic       i_sleep_enter,
  input logic       i_sleep_idle_mode,
  input logic       o_op_start,
  input logic [6:0] o_op_cmd,
  input logic [1:0] o_data_space_section,
  input logic       o_boot_read_zero,
  input logic       o_eeprom_idle_irq,
  input logic       o_wake_request,
  input logic       o_ctrl_sleeping,
  input logic       o_keep_clock_on
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_arst_n);
  sequence s_cmd(code);
    i_reg_wr && i_reg_addr == 4'h0 && i_reg_wdata == code;
  endsequence
  // Clearing first means no collision can swallow the erase.
  AST_IMM_ERASE:
    assert property (s_cmd(8'h00) ##0 i_self_program_key ##1 !i_reg_wr
      ##1 s_cmd(8'h30) ##0 i_self_program_key
      |=> o_op_start && o_op_cmd == 7'h30) else $error("erase not started");
  AST_WHOLE_CHIP_ERASE_PORT:
    assert property (s_cmd(8'h20) ##0 !i_from_debug_port
      |=> !(o_op_start && o_op_cmd == 7'h20)) else $error("cpu chip erase");
  AST_KEY_NEEDED:
    assert property (s_cmd(8'h30) ##0 !i_self_program_key
      |=> !(o_op_start && o_op_cmd == 7'h30)) else $error("keyless erase");
  AST_START_CODE:
    assert property (o_op_start |-> o_op_cmd inside {7'h02, [7'h08:7'h0d],
      7'h12, 7'h13, [7'h18:7'h1d], 7'h20, 7'h30}) else $error("bad code");
  AST_MAP_SMALL:
    assert property (FLASH_KB == 32 |-> o_data_space_section == 2'h0)
      else $error("section not zero");
  AST_WAKE_IDLE:
    assert property (o_wake_request |-> o_eeprom_idle_irq
      && $past(i_sleep_enter && i_sleep_idle_mode)) else $error("bad wake");
  AST_SLEEP_SPLIT:
    assert property ($past(i_arst_n) && $past(i_sleep_enter)
      |-> o_ctrl_sleeping != o_keep_clock_on) else $error("sleep split");
  AST_AWAKE:
    assert property (!$past(i_sleep_enter)
      |-> !o_ctrl_sleeping && !o_keep_clock_on) else $error("asleep early");
  AST_BOOT_LEFT:
    assert property ($rose(o_boot_read_zero) |-> !$past(i_exec_in_boot))
      else $error("boot guard while in boot");
endmodule // nvm_cmd_prot_checker

bind nvm_command_protection_ctrl nvm_cmd_prot_checker #(
  .FLASH_KB(FLASH_KB)) u_nvm_cmd_prot_checker (.*);

// ---- verif/test_nvm_command_protection_ctrl.sv ----
// Register-level tests of the command and protection controller.
// Assumes the array stand-in model and the bound checker.
`timescale 1ns/1ps
module test_nvm_command_protection_ctrl;
  logic i_core_clk = 1'b0, i_arst_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic i_self_program_key = 1'b0, i_io_register_key = 1'b0;
  logic i_from_debug_port = 1'b0, i_exec_in_boot = 1'b0, i_store_valid = 1'b0;
  logic i_array_rvalid = 1'b0, i_eeprom_preserve_fuse = 1'b1;
  logic i_sleep_enter = 1'b0, i_sleep_idle_mode = 1'b0;
  logic i_flash_busy_pin, i_eeprom_busy_pin, o_op_start, o_boot_read_zero;
  logic o_chip_erase_skip_eeprom, o_boot_fetch_no_operation_cmd, o_eeprom_idle_irq;
  logic o_wake_request, o_ctrl_sleeping, o_keep_clock_on;
  logic [3:0]  i_reg_addr = 4'h0;
  logic [7:0]  i_reg_wdata = 8'h00, o_reg_rdata;
  logic [1:0]  i_store_section = 2'h0, o_data_space_section;
  logic [23:0] i_store_addr = 24'h000000, o_op_addr;
  logic [15:0] i_store_data = 16'h0000, i_array_rdata = 16'h0000, o_op_data;
  logic [6:0]  o_op_cmd;
  logic [6:0]  codes [0:14] = '{7'h02, 7'h08, 7'h09, 7'h0a, 7'h0b, 7'h0c,
    7'h0d, 7'h12, 7'h13, 7'h18, 7'h19, 7'h1a, 7'h1b, 7'h1c, 7'h1d};
  int n_mismatch = 0, n_checks = 0, i;

  nvm_command_protection_ctrl u_nvm_command_protection_ctrl (.*);
  nvm_array_model u_nvm_array_model (.i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n), .i_op_start(o_op_start), .i_op_cmd(o_op_cmd),
    .o_flash_busy(i_flash_busy_pin), .o_eeprom_busy(i_eeprom_busy_pin));

  always #2.5 i_core_clk = ~i_core_clk;

  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Keys are levels that must stand beside the strobe they unlock.
  task wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] k);
    @(posedge i_core_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    {i_io_register_key, i_self_program_key} <= k;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
    {i_io_register_key, i_self_program_key} <= 2'b00;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge i_core_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
    #1 chk(o_reg_rdata & m, e);
  endtask
  task st(input logic [1:0] s, input logic e);
    @(posedge i_core_clk);
    i_store_valid <= 1'b1;
    i_store_section <= s;
    i_store_addr <= i_store_addr + 24'h000011;
    @(posedge i_core_clk);
    i_store_valid <= 1'b0;
    #1 chk({7'h00, o_op_start}, {7'h00, e});
    if (e) chk(o_op_addr[7:0], i_store_addr[7:0]);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    wrap_up;
  end

  initial begin
    repeat (16) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    repeat (8) @(posedge i_core_clk);
    rd(4'h1, 8'hff, 8'h30);
    wr(4'h4, 8'h01, 2'b00);
    rd(4'h4, 8'h01, 8'h01);
    wr(4'h1, 8'h15, 2'b00);
    rd(4'h1, 8'hff, 8'h10);
    wr(4'h1, 8'h85, 2'b10);
    rd(4'h1, 8'hff, 8'h85);
    wr(4'h1, 8'h30, 2'b10);
    rd(4'h1, 8'hff, 8'h85);
    wr(4'h1, 8'h87, 2'b10);
    rd(4'h1, 8'hff, 8'h85);
    i_exec_in_boot <= 1'b1;
    wr(4'h1, 8'h87, 2'b10);
    rd(4'h1, 8'hff, 8'h87);
    i_exec_in_boot <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    #1 chk({6'h00, o_boot_read_zero, o_boot_fetch_no_operation_cmd}, 8'h03);
    $display("protection test done");
    wr(4'h0, 8'h30, 2'b10);
    rd(4'h0, 8'hff, 8'h00);
    for (i = 0; i < 15; i++) begin
      wr(4'h0, {1'b0, codes[i]}, 2'b01);
      rd(4'h0, 8'hff, {1'b0, codes[i]});
      st((codes[i] >= 7'h12) ? 2'h3 : 2'h0, 1'b1);
      chk({1'b0, o_op_cmd}, {1'b0, codes[i]});
      wr(4'h0, 8'h00, 2'b01);
    end
    $display("command table test done");
    wr(4'h0, 8'h03, 2'b01);
    rd(4'h2, 8'h70, 8'h10);
    st(2'h0, 1'b0);
    wr(4'h2, 8'h00, 2'b00);
    rd(4'h2, 8'h70, 8'h00);
    wr(4'h0, 8'h02, 2'b01);
    st(2'h3, 1'b0);
    st(2'h2, 1'b0);
    rd(4'h2, 8'h70, 8'h20);
    st(2'h1, 1'b0);
    wr(4'h0, 8'h08, 2'b01);
    rd(4'h2, 8'h70, 8'h30);
    rd(4'h0, 8'hff, 8'h02);
    wr(4'h0, 8'h00, 2'b01);
    wr(4'h0, 8'h20, 2'b01);
    rd(4'h2, 8'h70, 8'h10);
    i_from_debug_port <= 1'b1;
    wr(4'h0, 8'h20, 2'b01);
    #1 chk({6'h00, o_op_start, o_chip_erase_skip_eeprom}, 8'h03);
    i_from_debug_port <= 1'b0;
    $display("error test done");
    wr(4'h3, 8'h01, 2'b00);
    wr(4'h0, 8'h00, 2'b01);
    wr(4'h0, 8'h30, 2'b01);
    #1 chk({o_op_start, o_op_cmd}, 8'hb0);
    i_sleep_enter <= 1'b1;
    repeat (8) @(posedge i_core_clk);
    #1 chk({6'h00, o_ctrl_sleeping, o_keep_clock_on}, 8'h01);
    wr(4'h4, 8'h01, 2'b00);
    rd(4'h4, 8'h01, 8'h00);
    chk({7'h00, o_eeprom_idle_irq}, 8'h00);
    repeat (30) @(posedge i_core_clk);
    #1 chk({5'h00, o_ctrl_sleeping, o_keep_clock_on, o_wake_request},
      8'h04);
    i_sleep_idle_mode <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    #1 chk({6'h00, o_eeprom_idle_irq, o_wake_request}, 8'h03);
    i_sleep_enter <= 1'b0;
    i_sleep_idle_mode <= 1'b0;
    $display("sleep test done");
    wrap_up;
  end
endmodule // test_nvm_command_protection_ctrl
